/* cmd_if.sv */
`timescale 1ns/100ps
interface cmd_if;
  import node_regs_pkg::*;
  logic [WORD_W-1:0] wr_bits;
  logic [WORD_W-1:0] done;
  logic [WORD_W-1:0] pending;
  logic [WORD_W-1:0] start;
  modport main (output wr_bits, output done, input pending, input start);
  modport seq  (input wr_bits, input done, output pending, output start);
endinterface : cmd_if

/* cmd_sequencer.sv */
`timescale 1ns/100ps
module cmd_sequencer
  import node_regs_pkg::*;
#(
  parameter logic [WORD_W-1:0] INTERNAL_MASK = CMD_INTERNAL_MASK
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  cmd_if.seq       bus
);
  logic [WORD_W-1:0] finish;

  assign finish    = bus.done | INTERNAL_MASK;
  // A relaunch in the finishing cycle starts again, so no write is lost
  assign bus.start = bus.wr_bits & (~bus.pending | finish);  // see (R1)

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bus.pending <= '0;
    else if (ce)
      bus.pending <= (bus.pending & ~finish) | bus.wr_bits;  // see (R1)
  end

  chk_cmd_self_clear: assert property (  // see (R1)
    @(posedge clk) disable iff (rst || !ce)
    ((bus.pending & finish & ~bus.wr_bits) != '0)
      |=> ((bus.pending & $past(bus.pending & finish & ~bus.wr_bits)) == '0))
    else $error("finished command bit did not return to zero");
endmodule : cmd_sequencer

/* node_command_and_id_registers.sv */
`timescale 1ns/100ps
// Summary of operation
// (R1) A written 1 launches its command; the bit clears itself when done.
// (R2) Command word sits at 0x36 on node pages and reads back zero.
// (R3) Bit 8 (word 0xB701) clears the capture buffers and records.
// (R4) Bit 14 loads alarm bands chosen by the alarm band pointer.
// (R5) Bit 13 fetches a stored record from flash into output registers.
// (R6) Bit 12 copies alarm band registers into working SRAM.
// (R7) Bit 10 forces the buffer pointer to zero.
// (R8) Bit 9 erases alarm band settings held in flash.
// (R9) Bit 6 saves configuration registers into flash.
// (R10) Bit 5 sums flash contents and compares with the factory value.
// (R11) Bit 3 restores factory register values and empties capture buffers.
// (R12) Bit 2 runs self-test; result lands in diagnostic status bit 5.
// (R13) Two-bit pin function: general, alarm, busy/data-ready, unused.
// (R14) Pin control at 0x2A is read/write, resets to 0x0008.
// (R15) Gateway serial number word reads at 0x24.
// (R16) Each node page has a scratch word at 0x64, reset zero.
// (R17) Flash checksum result lands in diagnostic status bit 6.
// (R18) Pin control bits 1 and 0 set polarity, 1 active high.
// (R19) Bits 15,11,7,4,1,0: autonull clear, record toggle, reset, diag clear, etc.
// (R20) Host issues commands only while the supply stays in range.
module node_command_and_id_registers
  import node_regs_pkg::*;
#(
  parameter logic [WORD_W-1:0] PRODUCT_GW   = 16'h1111,  // Arbitrary value
  parameter logic [WORD_W-1:0] PRODUCT_NODE = 16'h2222,  // Arbitrary value
  parameter logic [WORD_W-1:0] BATCH_LO_GW  = 16'h0A01,  // Arbitrary value
  parameter logic [WORD_W-1:0] BATCH_HI_GW  = 16'h0A02,  // Arbitrary value
  parameter logic [WORD_W-1:0] BATCH_LO_ND  = 16'h0B01,  // Arbitrary value
  parameter logic [WORD_W-1:0] BATCH_HI_ND  = 16'h0B02,  // Arbitrary value
  parameter logic [WORD_W-1:0] SERIAL_GW    = 16'h0C01   // Arbitrary value
)(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               ce,
  input wire logic               sclk,
  input wire logic               cs_n,
  input wire logic               mosi,
  output logic                   miso,
  input wire logic [WORD_W-1:0]  cmd_done,
  input wire logic               selftest_fail,
  input wire logic               checksum_fail,
  input wire logic               alarm_active,
  input wire logic               data_ready,
  output logic [WORD_W-1:0]      cmd_start,
  output logic [PAGE_W-1:0]      cmd_node,
  output logic                   record_run,
  output logic                   output_pin_one,
  output logic                   output_pin_two
);
  logic [2:0]              pin_raw;
  logic [2:0]              sync1;
  logic [2:0]              sync2;
  logic [2:0]              sync3;
  logic [2:0]              filt;
  logic                    sclk_d;
  logic                    sclk_rise;
  logic                    sclk_fall;
  link_state_e             state;
  logic [3:0]              bit_cnt;
  logic [WORD_W-1:0]       rx_shift;
  logic [WORD_W-1:0]       tx_shift;
  logic [WORD_W-1:0]       rx_word;
  logic                    word_valid;
  logic [WORD_W-1:0]       read_word;
  logic [WORD_W-1:0]       next_read;
  logic [PAGE_W-1:0]       page;
  logic                    node_pg;
  logic                    wr_req;
  logic [ADDR_W-1:0]       byte_addr;
  logic [ADDR_W-1:0]       word_addr;
  logic                    hi_byte;
  logic [7:0]              wr_data;
  logic [WORD_W-1:0]       pin_ctrl;
  logic [WORD_W-1:0]       buffer_pointer;
  logic [WORD_W-1:0]       diag;
  logic [WORD_W-1:0]       scratch [NODE_PAGES];
  logic                    restore;
  logic [PIN_COUNT-1:0]    pin_out;

  cmd_if cmd ();

  function automatic logic [WORD_W-1:0] put_byte(input logic [WORD_W-1:0] old,
                                                 input logic              hi,
                                                 input logic [7:0]        b);
    put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : put_byte

  // Pin inputs: three stages, a level is taken once stages two and three agree
  assign pin_raw = {cs_n, sclk, mosi};

  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        sync1[i] <= PIN_IDLE[i];
        sync2[i] <= PIN_IDLE[i];
        sync3[i] <= PIN_IDLE[i];
        filt[i]  <= PIN_IDLE[i];
      end
      else if (ce)
      begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i])
          filt[i] <= sync3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sclk_d <= PIN_IDLE[1];
    else if (ce)
      sclk_d <= filt[1];
  end

  assign sclk_rise = filt[1] & ~sclk_d;
  assign sclk_fall = ~filt[1] & sclk_d;

  // Serial frame engine: 16-bit words, MSB first, sampled on the rising edge.
  // A read answer goes out in the frame after the read request.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= ST_IDLE;
      bit_cnt    <= '0;
      rx_shift   <= '0;
      tx_shift   <= '0;
      rx_word    <= '0;
      word_valid <= 1'b0;
      miso       <= 1'b0;
    end
    else if (ce)
    begin
      word_valid <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (!filt[2])
          begin
            state    <= ST_SHIFT;
            bit_cnt  <= '0;
            miso     <= read_word[WORD_W-1];
            // Whole word kept: the first sclk fall presents the MSB again
            tx_shift <= read_word;
          end
        end
        ST_SHIFT:
        begin
          if (filt[2])
            state <= ST_IDLE;
          else
          begin
            if (sclk_rise)
            begin
              rx_shift <= {rx_shift[WORD_W-2:0], filt[0]};
              bit_cnt  <= bit_cnt + 4'h1;
              if (bit_cnt == LAST_BIT)
              begin
                rx_word    <= {rx_shift[WORD_W-2:0], filt[0]};
                word_valid <= 1'b1;
              end
            end
            if (sclk_fall)
            begin
              miso     <= tx_shift[WORD_W-1];
              tx_shift <= {tx_shift[WORD_W-2:0], 1'b0};
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Decode of a received word
  assign wr_req    = word_valid & rx_word[WR_FLAG_BIT];
  assign byte_addr = rx_word[14:8];
  assign word_addr = {byte_addr[ADDR_W-1:1], 1'b0};
  assign hi_byte   = byte_addr[0];
  assign wr_data   = rx_word[7:0];
  assign node_pg   = (page != PAGE_GATEWAY);

  always_comb
  begin
    cmd.wr_bits = '0;
    if (wr_req && node_pg && word_addr == ADDR_CMD)
      cmd.wr_bits = hi_byte ? {wr_data, 8'h00} : {8'h00, wr_data};  // see (R1)
  end

  assign cmd.done = cmd_done;
  // Soft reset and factory restore both bring pin control, buffer pointer, scratch and diag to defaults
  assign restore  = cmd.start[CMD_SOFT_RESET] | cmd.start[CMD_FACTORY];  // see (R11)

  cmd_sequencer u_seq (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .bus (cmd.seq)
  );

  // Launch pulses to the flash, record and sensor engines outside this block
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_start <= '0;
      cmd_node  <= PAGE_GATEWAY;
    end
    else if (ce)
    begin
      cmd_start <= cmd.start;  // see (R3) (R4) (R5) (R6) (R8) (R9) (R10) (R19)
      if (cmd.wr_bits != '0)
        cmd_node <= page;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      page <= PAGE_GATEWAY;
    else if (ce && wr_req && word_addr == ADDR_PAGE && !hi_byte)
      if (wr_data <= 8'(NODE_PAGES))
        page <= wr_data[PAGE_W-1:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin_ctrl <= PIN_CTRL_RESET;
    else if (ce)
    begin
      if (restore)
        pin_ctrl <= PIN_CTRL_RESET;  // see (R14)
      else if (wr_req && !node_pg && word_addr == ADDR_PIN_CTRL)
        pin_ctrl <= put_byte(pin_ctrl, hi_byte, wr_data) & PIN_CTRL_MASK;  // see (R14)
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      buffer_pointer <= BUF_PTR_RESET;
    else if (ce)
    begin
      if (restore || cmd.start[CMD_ZERO_BUF_PTR])
        buffer_pointer <= BUF_PTR_RESET;  // see (R7)
      else if (wr_req && node_pg && word_addr == ADDR_BUF_PTR)
        buffer_pointer <= put_byte(buffer_pointer, hi_byte, wr_data);
    end
  end

  for (genvar g = 0; g < NODE_PAGES; g++)
  begin : g_scratch
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        scratch[g] <= SCRATCH_RESET;
      else if (ce)
      begin
        if (restore)
          scratch[g] <= SCRATCH_RESET;  // see (R16)
        else if (wr_req && word_addr == ADDR_SCRATCH && page == PAGE_W'(g + 1))
          scratch[g] <= put_byte(scratch[g], hi_byte, wr_data);  // see (R16)
      end
    end
  end

  // Test results win over a clear arriving in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      diag <= DIAG_RESET;
    else if (ce)
    begin
      if (cmd.start[CMD_CLEAR_DIAG] || restore)
        diag <= DIAG_RESET;  // see (R19)
      if (cmd.pending[CMD_SELF_TEST] && cmd_done[CMD_SELF_TEST])
        diag[DIAG_SELF_TEST_BIT] <= selftest_fail;  // see (R12)
      if (cmd.pending[CMD_FLASH_TEST] && cmd_done[CMD_FLASH_TEST])
        diag[DIAG_FLASH_TEST_BIT] <= checksum_fail;  // see (R10) (R17)
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      record_run <= 1'b0;
    else if (ce && cmd.start[CMD_RECORD_TOGGLE])
      record_run <= ~record_run;  // see (R19)
  end

  // Read mux; unmapped words and the command word read as zero
  always_comb
  begin
    next_read = '0;
    if (word_addr == ADDR_PAGE)
      next_read = WORD_W'(page);
    else if (!node_pg)
    begin
      case (word_addr)
        ADDR_PROD_GW:     next_read = PRODUCT_GW;
        ADDR_BATCH_LO_GW: next_read = BATCH_LO_GW;
        ADDR_BATCH_HI_GW: next_read = BATCH_HI_GW;
        ADDR_SERIAL_GW:   next_read = SERIAL_GW;  // see (R15)
        ADDR_PIN_CTRL:    next_read = pin_ctrl;  // see (R14)
        default:          next_read = '0;
      endcase
    end
    else
    begin
      case (word_addr)
        ADDR_BUF_PTR:       next_read = buffer_pointer;
        ADDR_DIAG:          next_read = diag;
        ADDR_CMD:           next_read = '0;  // see (R2)
        ADDR_PROD_NODE:     next_read = PRODUCT_NODE;
        ADDR_SCRATCH:       next_read = scratch[page - PAGE_W'(1)];  // see (R16)
        ADDR_BATCH_LO_NODE: next_read = BATCH_LO_ND;
        ADDR_BATCH_HI_NODE: next_read = BATCH_HI_ND;
        default:            next_read = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      read_word <= '0;
    else if (ce && word_valid && !rx_word[WR_FLAG_BIT])
      read_word <= next_read;
  end

  // Busy covers command execution and real-time data ready
  for (genvar p = 0; p < PIN_COUNT; p++)
  begin : g_pin
    pin_driver u_pin (
      .clk         (clk),
      .rst         (rst),
      .ce          (ce),
      .func_sel    (pin_ctrl[PIN_SEL_BASE + PIN_SEL_W*p +: PIN_SEL_W]),
      .active_high (pin_ctrl[p]),
      .alarm       (alarm_active),
      .busy        ((cmd.pending != '0) | data_ready),
      .pin         (pin_out[p])
    );
  end

  assign output_pin_one = pin_out[0];
  assign output_pin_two = pin_out[1];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || !ce);

  chk_cmd_launch: assert property (  // see (R1)
    (cmd.wr_bits[CMD_AUTONULL] && !cmd.pending[CMD_AUTONULL])
      |=> (cmd_start[CMD_AUTONULL] && cmd.pending[CMD_AUTONULL]))
    else $error("command write did not launch");

  chk_clear_records: assert property (  // see (R3)
    (word_valid && rx_word == CLEAR_RECORDS_WORD && node_pg
     && !cmd.pending[CMD_CLEAR_RECORDS])
      |=> cmd_start[CMD_CLEAR_RECORDS])
    else $error("clear records word did not launch bit 8");

  chk_cmd_read_zero: assert property (  // see (R2)
    (word_valid && !rx_word[WR_FLAG_BIT] && node_pg && word_addr == ADDR_CMD)
      |=> (read_word == '0))
    else $error("command word read back nonzero");

  chk_buf_ptr_zero: assert property (  // see (R7)
    cmd.start[CMD_ZERO_BUF_PTR] |=> (buffer_pointer == BUF_PTR_RESET))
    else $error("buffer pointer not zeroed");

  chk_restore_pins: assert property (  // see (R11) (R14)
    (restore && !(cmd.pending[CMD_SELF_TEST] && cmd_done[CMD_SELF_TEST])
     && !(cmd.pending[CMD_FLASH_TEST] && cmd_done[CMD_FLASH_TEST]))
      |=> (pin_ctrl == PIN_CTRL_RESET && diag == DIAG_RESET))
    else $error("restore left registers off default");

  chk_self_test_result: assert property (  // see (R12)
    (cmd.pending[CMD_SELF_TEST] && cmd_done[CMD_SELF_TEST])
      |=> (diag[DIAG_SELF_TEST_BIT] == $past(selftest_fail)) && !cmd.pending[CMD_SELF_TEST])
    else $error("self-test result not reported");

  chk_flash_test_result: assert property (  // see (R17)
    (cmd.pending[CMD_FLASH_TEST] && cmd_done[CMD_FLASH_TEST])
      |=> (diag[DIAG_FLASH_TEST_BIT] == $past(checksum_fail)))
    else $error("checksum result not reported");

  chk_record_toggle: assert property (  // see (R19)
    cmd.start[CMD_RECORD_TOGGLE] |=> (record_run != $past(record_run)))
    else $error("record run did not toggle");
endmodule : node_command_and_id_registers

/* node_regs_pkg.sv */
package node_regs_pkg;
  localparam int        WORD_W     = 16;
  localparam int        ADDR_W     = 7;
  localparam int        PAGE_W     = 3;
  localparam int        NODE_PAGES = 6;
  localparam int        PIN_COUNT  = 2;
  localparam int        PIN_SYNC_N = 3;
  // Register byte addresses (low byte of each word)
  localparam logic [ADDR_W-1:0] ADDR_PAGE          = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_BUF_PTR       = 7'h10;
  localparam logic [ADDR_W-1:0] ADDR_PROD_GW       = 7'h16;
  localparam logic [ADDR_W-1:0] ADDR_BATCH_LO_GW   = 7'h1A;
  localparam logic [ADDR_W-1:0] ADDR_BATCH_HI_GW   = 7'h1C;
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_GW     = 7'h24;
  localparam logic [ADDR_W-1:0] ADDR_PIN_CTRL      = 7'h2A;
  localparam logic [ADDR_W-1:0] ADDR_DIAG          = 7'h34;
  localparam logic [ADDR_W-1:0] ADDR_CMD           = 7'h36;
  localparam logic [ADDR_W-1:0] ADDR_PROD_NODE     = 7'h48;
  localparam logic [ADDR_W-1:0] ADDR_SCRATCH       = 7'h64;
  localparam logic [ADDR_W-1:0] ADDR_BATCH_LO_NODE = 7'h68;
  localparam logic [ADDR_W-1:0] ADDR_BATCH_HI_NODE = 7'h6A;
  localparam logic [PAGE_W-1:0] PAGE_GATEWAY       = 3'h0;
  // Command word bit positions
  localparam int CMD_CLR_AUTONULL  = 15;
  localparam int CMD_LOAD_BANDS    = 14;
  localparam int CMD_FETCH_RECORD  = 13;
  localparam int CMD_SAVE_BANDS    = 12;
  localparam int CMD_RECORD_TOGGLE = 11;
  localparam int CMD_ZERO_BUF_PTR  = 10;
  localparam int CMD_ERASE_BANDS   = 9;
  localparam int CMD_CLEAR_RECORDS = 8;
  localparam int CMD_SOFT_RESET    = 7;
  localparam int CMD_SAVE_CONFIG   = 6;
  localparam int CMD_FLASH_TEST    = 5;
  localparam int CMD_CLEAR_DIAG    = 4;
  localparam int CMD_FACTORY       = 3;
  localparam int CMD_SELF_TEST     = 2;
  localparam int CMD_POWER_DOWN    = 1;
  localparam int CMD_AUTONULL      = 0;
  // Commands finished by this block alone, one cycle after launch
  localparam logic [WORD_W-1:0] CMD_INTERNAL_MASK  = 16'h0C90;
  localparam logic [WORD_W-1:0] CLEAR_RECORDS_WORD = 16'hB701;
  localparam int DIAG_SELF_TEST_BIT  = 5;
  localparam int DIAG_FLASH_TEST_BIT = 6;
  localparam logic [WORD_W-1:0] DIAG_RESET      = 16'h0000;
  localparam logic [WORD_W-1:0] PIN_CTRL_RESET  = 16'h0008;
  localparam logic [WORD_W-1:0] PIN_CTRL_MASK   = 16'h003F;
  localparam logic [WORD_W-1:0] SCRATCH_RESET   = 16'h0000;
  localparam logic [WORD_W-1:0] BUF_PTR_RESET   = 16'h0000;
  localparam int PIN_SEL_BASE  = 2;
  localparam int PIN_SEL_W     = 2;
  localparam int WR_FLAG_BIT   = 15;
  localparam logic [3:0] LAST_BIT = 4'hF;
  // Filtered idle levels of {cs_n, sclk, mosi}
  localparam logic [2:0] PIN_IDLE = 3'h6;

  typedef enum logic [1:0] {
    FUNC_GP     = 2'h0,
    FUNC_ALARM  = 2'h1,
    FUNC_BUSY   = 2'h2,
    FUNC_UNUSED = 2'h3
  } pin_func_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h1,
    ST_SHIFT = 2'h2
  } link_state_e;
endpackage : node_regs_pkg

/* pin_driver.sv */
`timescale 1ns/100ps
module pin_driver
  import node_regs_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 ce,
  input wire logic [PIN_SEL_W-1:0] func_sel,
  input wire logic                 active_high,
  input wire logic                 alarm,
  input wire logic                 busy,
  output logic                     pin
);
  logic asserted;

  always_comb
  begin
    case (func_sel)  // see (R13)
      FUNC_GP:    asserted = 1'b1;
      FUNC_ALARM: asserted = alarm;
      FUNC_BUSY:  asserted = busy;
      default:    asserted = 1'b0;
    endcase
  end

  // Reset level matches pin one's default: busy function, active low, idle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin <= 1'b1;
    else if (ce)
      pin <= asserted ? active_high : ~active_high;  // see (R18)
  end

  chk_pin_level: assert property (  // see (R13)
    @(posedge clk) disable iff (rst || !ce)
    (func_sel == FUNC_ALARM) |=> (pin == ($past(alarm) ~^ $past(active_high))))
    else $error("alarm function pin level wrong");
endmodule : pin_driver

/* serial_host.sv */
`timescale 1ns/100ps
module serial_host
  import node_regs_pkg::*;
#(
  parameter int HALF = 10
)(
  input  wire logic clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  // Supply taken as in range for every frame; no brown-out stimulus
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Half period of 10 clocks keeps well clear of the pin filter latency
  task automatic xfer(input logic [WORD_W-1:0] tx, output logic [WORD_W-1:0] rx);
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = WORD_W - 1; i >= 0; i--)
    begin
      sclk <= 1'b0;
      mosi <= tx[i];
      repeat (HALF) @(posedge clk);
      sclk <= 1'b1;
      rx[i] = miso;
      repeat (HALF) @(posedge clk);
    end
    cs_n <= 1'b1;
    // Released data line must not keep its last bit
    mosi <= ~mosi;
    repeat (HALF) @(posedge clk);
  endtask : xfer
endmodule : serial_host

/* testbench.sv */
`timescale 1ns/100ps
module testbench;
  import node_regs_pkg::*;
  localparam logic [WORD_W-1:0] ID_VAL [7] = '{16'h5A01, 16'h5A02, 16'h5A03, 16'h5A04,
                                               16'h6B01, 16'h6B02, 16'h6B03};
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              ce = 1'b1;
  logic              sclk;
  logic              cs_n;
  logic              mosi;
  logic              miso;
  logic [WORD_W-1:0] cmd_done = '0;
  logic              selftest_fail = 1'b0;
  logic              checksum_fail = 1'b0;
  logic              alarm_active = 1'b0;
  logic              data_ready = 1'b0;
  logic [WORD_W-1:0] cmd_start;
  logic [PAGE_W-1:0] cmd_node;
  logic              record_run;
  logic              output_pin_one;
  logic              output_pin_two;
  logic [31:0]       seed = 32'h3393;
  int                error_cnt = 0;
  int                n_tests = 0;
  int                starts [WORD_W];
  logic [ADDR_W-1:0] id_addr [7] = '{ADDR_PROD_GW, ADDR_BATCH_LO_GW, ADDR_BATCH_HI_GW,
                                     ADDR_SERIAL_GW, ADDR_PROD_NODE, ADDR_BATCH_LO_NODE,
                                     ADDR_BATCH_HI_NODE};

  always #12.5 clk = ~clk;

  // Launch pulses stand one cycle, so count them as they pass
  always @(posedge clk)
    for (int i = 0; i < WORD_W; i++)
      if (cmd_start[i] === 1'b1)
        starts[i]++;

  node_command_and_id_registers #(
    .PRODUCT_GW(ID_VAL[0]), .BATCH_LO_GW(ID_VAL[1]), .BATCH_HI_GW(ID_VAL[2]),
    .SERIAL_GW(ID_VAL[3]), .PRODUCT_NODE(ID_VAL[4]), .BATCH_LO_ND(ID_VAL[5]),
    .BATCH_HI_ND(ID_VAL[6])
  ) node_command_and_id_registers_i (
    .clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .cmd_done(cmd_done), .selftest_fail(selftest_fail), .checksum_fail(checksum_fail),
    .alarm_active(alarm_active), .data_ready(data_ready), .cmd_start(cmd_start),
    .cmd_node(cmd_node), .record_run(record_run), .output_pin_one(output_pin_one),
    .output_pin_two(output_pin_two)
  );

  serial_host serial_host_i (
    .clk(clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi)
  );

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic lvl(input logic [1:0] f, input logic pol);
    logic act;
    act = (f == FUNC_ALARM) ? alarm_active : data_ready;
    if (f == FUNC_GP)
      return pol;
    if (f == FUNC_UNUSED)
      return ~pol;
    return act ? pol : ~pol;
  endfunction : lvl

  task automatic check(input string what, input logic [WORD_W-1:0] seen,
                       input logic [WORD_W-1:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [WORD_W-1:0] r;
    serial_host_i.xfer({1'b1, a, d}, r);
  endtask : wr

  // The answer to a read comes out in the following frame
  task automatic rdchk(input string what, input logic [ADDR_W-1:0] a,
                       input logic [WORD_W-1:0] exp);
    logic [WORD_W-1:0] d;
    serial_host_i.xfer({1'b0, a, 8'h00}, d);
    serial_host_i.xfer({1'b0, a, 8'h00}, d);
    check(what, d, exp);
  endtask : rdchk

  task automatic wrap_up();
    $display("SUMMARY comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    logic [31:0]       r;
    logic [WORD_W-1:0] ctrl;
    logic [WORD_W-1:0] diag;
    logic              internal;
    int                c;
    repeat (8) @(posedge clk);
    check("pin one in reset", output_pin_one, 1'b1);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("pin one idle", output_pin_one, 1'b1);
    check("pin two", output_pin_two, 1'b0);
    check("record run", record_run, 1'b0);
    rdchk("pin ctrl reset", ADDR_PIN_CTRL, PIN_CTRL_RESET);
    for (int i = 0; i < 7; i++)
    begin
      if (i == 4)
        wr(ADDR_PAGE, 8'h01);
      wr(id_addr[i], 8'hFF);
      rdchk("id word", id_addr[i], ID_VAL[i]);
    end
    $display("TEST ids done");
    rdchk("scratch reset", ADDR_SCRATCH, SCRATCH_RESET);
    rdchk("cmd readback", ADDR_CMD, 16'h0000);
    r = xs();
    wr(ADDR_PAGE, 8'h02);
    wr(ADDR_SCRATCH, r[7:0]);
    wr(ADDR_SCRATCH + 7'h01, r[15:8]);
    // Page 8 is refused, so page 2 must stay selected
    wr(ADDR_PAGE, 8'h08);
    rdchk("scratch", ADDR_SCRATCH, r[15:0]);
    wr(ADDR_PAGE, 8'h01);
    rdchk("scratch other page", ADDR_SCRATCH, SCRATCH_RESET);
    $display("TEST scratch done");
    wr(ADDR_PAGE, 8'h00);
    c = starts[0];
    wr(ADDR_CMD, 8'h01);
    check("gateway cmd", 16'(starts[0] - c), 16'h0000);
    // A frame sent while the clock enable is low must leave no trace
    ce <= 1'b0;
    wr(ADDR_PIN_CTRL, 8'h3F);
    ce <= 1'b1;
    rdchk("pin ctrl frozen", ADDR_PIN_CTRL, PIN_CTRL_RESET);
    for (int f = 0; f < 4; f++)
    begin
      r = xs();
      alarm_active <= r[2];
      data_ready <= r[3];
      ctrl = {10'h000, 2'(3 - f), 2'(f), r[1:0]};
      wr(ADDR_PIN_CTRL, ctrl[7:0]);
      wr(ADDR_PIN_CTRL + 7'h01, r[15:8]);
      rdchk("pin ctrl", ADDR_PIN_CTRL, ctrl);
      check("pin one", output_pin_one, lvl(ctrl[3:2], ctrl[0]));
      check("pin two", output_pin_two, lvl(ctrl[5:4], ctrl[1]));
    end
    $display("TEST pins done");
    data_ready <= 1'b0;
    wr(ADDR_PIN_CTRL, 8'h08);
    wr(ADDR_PAGE, 8'h01);
    r = xs();
    wr(ADDR_BUF_PTR, r[7:0] | 8'h01);
    diag = '0;
    for (int b = WORD_W - 1; b >= 0; b--)
    begin
      c = starts[b];
      r = xs();
      internal = CMD_INTERNAL_MASK[b];
      selftest_fail <= r[0];
      checksum_fail <= r[1];
      // Bit 8 goes out as the serial word 0xB701
      wr(ADDR_CMD + 7'(b / 8), 8'(1 << (b % 8)));
      check("launch", 16'(starts[b] - c), 16'h0001);
      check("node", cmd_node, 3'h1);
      if (b == CMD_RECORD_TOGGLE)
        check("record run", record_run, 1'b1);
      if (!internal)
        check("busy pin", output_pin_one, 1'b0);
      wr(ADDR_CMD + 7'(b / 8), 8'(1 << (b % 8)));
      check("relaunch", 16'(starts[b] - c), internal ? 16'h0002 : 16'h0001);
      @(posedge clk);
      cmd_done[b] <= 1'b1;
      @(posedge clk);
      cmd_done <= '0;
      if (b == CMD_FLASH_TEST)
        diag[DIAG_FLASH_TEST_BIT] = r[1];
      if (b == CMD_SELF_TEST)
        diag[DIAG_SELF_TEST_BIT] = r[0];
      if (b == CMD_SOFT_RESET || b == CMD_CLEAR_DIAG || b == CMD_FACTORY)
        diag = '0;
      repeat (4) @(posedge clk);
      check("busy released", output_pin_one, 1'b1);
      rdchk("diag", ADDR_DIAG, diag);
      if (b == CMD_ZERO_BUF_PTR)
        rdchk("buf ptr", ADDR_BUF_PTR, BUF_PTR_RESET);
    end
    $display("TEST commands done");
    wrap_up();
  end
endmodule : testbench
